// file: hdl/adc_sequence_control.sv
// sequencer, successive approximation register and register file of the converter
`timescale 1ns/1ps
module adc_sequence_control #(
  parameter int TICK_DIV = adc_seq_pkg::TICK_DIV,
  parameter int SAMPLE_TICKS = adc_seq_pkg::SAMPLE_TICKS,
  parameter int BIT_TICKS = adc_seq_pkg::BIT_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire adc_seq_pkg::reg_req_t req,
  output logic [adc_seq_pkg::DATA_W-1:0] rdata,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic comp_in,
  output adc_seq_pkg::analog_ctrl_t analog
);
  import adc_seq_pkg::*;

  localparam int DIV_W = $clog2(TICK_DIV + 1);
  localparam int CNT_W = $clog2(SAMPLE_TICKS + BIT_TICKS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_TICKS - 1);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_TICKS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
  localparam logic [DIV_W-1:0] DIV_ZERO = DIV_W'(0);

  // channel code for a slot of the sequence
  function automatic logic [3:0] chan_of(
    input logic grp,
    input logic [3:0] sel,
    input logic [1:0] slot
  );
    chan_of = grp ? {sel[3:2], slot} : sel;
  endfunction

  seq_state_t state;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [CNT_W-1:0] phase_cnt;
  logic [2:0] bit_pos;
  logic [1:0] slot;
  logic [DATA_W-1:0] sar;
  logic [DATA_W-1:0] result [RESULT_COUNT];
  logic done_flag;
  logic cont_mode;
  logic group_mode;
  logic [3:0] chan_sel;
  logic comp_meta;
  logic comp_sync;

  wire ctrl_wr = req.wr && (req.addr == CTRL_ADDR);
  wire low_power = stop_mode | wait_mode;
  wire running = (state != IDLE);
  wire suspend = running && low_power;
  wire advance = running && !low_power && tick;
  wire sample_end = (phase_cnt == SAMPLE_LAST);
  wire bit_end = (phase_cnt == BIT_LAST);
  wire [DATA_W-1:0] trial_bit = ONE_HOT_LSB << bit_pos;
  wire [DATA_W-1:0] resolved = comp_sync ? sar : (sar & ~trial_bit);
  wire [DATA_W-1:0] next_trial = ONE_HOT_LSB << (bit_pos - 3'h1);
  wire last_bit = (bit_pos == LSB_POS);
  wire store = advance && (state == CONVERT) && bit_end && last_bit;
  wire seq_end = store && (slot == LAST_SLOT);
  wire [3:0] next_chan = chan_of(group_mode, chan_sel, slot);
  wire [DATA_W-1:0] ctrl_view = {done_flag, 1'b0, cont_mode, group_mode, chan_sel};

  // slower conversion rate as an enable pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= DIV_ZERO;
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == DIV_LAST);
      div_cnt <= (div_cnt == DIV_LAST) ? DIV_ZERO : div_cnt + DIV_W'(1);
    end
  end

  // comparator comes from the analog side
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  // control fields; done flag is not writable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cont_mode <= CONT_RESET;
      group_mode <= GROUP_RESET;
      chan_sel <= SEL_RESET;
    end else if (ctrl_wr) begin
      cont_mode <= req.wdata[CONT_BIT];
      group_mode <= req.wdata[GROUP_BIT];
      chan_sel <= req.wdata[3:0];
    end
  end

  // a write abandons the sequence, so it beats a completing one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= DONE_RESET;
    end else if (ctrl_wr) begin
      done_flag <= 1'b0;
    end else if (seq_end) begin
      done_flag <= 1'b1;
    end
  end

  // sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      phase_cnt <= CNT_ZERO;
      bit_pos <= MSB_POS;
      slot <= FIRST_SLOT;
      sar <= RESULT_RESET;
    end else if (ctrl_wr) begin
      state <= SAMPLE;
      phase_cnt <= CNT_ZERO;
      bit_pos <= MSB_POS;
      slot <= FIRST_SLOT;
      sar <= RESULT_RESET;
    end else if (suspend) begin
      // restart the current channel from its sample phase
      state <= SAMPLE;
      phase_cnt <= CNT_ZERO;
      bit_pos <= MSB_POS;
      sar <= RESULT_RESET;
    end else if (advance) begin
      case (state)
        SAMPLE: begin
          if (sample_end) begin
            state <= CONVERT;
            phase_cnt <= CNT_ZERO;
            sar <= trial_bit;
          end else begin
            phase_cnt <= phase_cnt + CNT_W'(1);
          end
        end
        CONVERT: begin
          if (!bit_end) begin
            phase_cnt <= phase_cnt + CNT_W'(1);
          end else if (!last_bit) begin
            phase_cnt <= CNT_ZERO;
            sar <= resolved | next_trial;
            bit_pos <= bit_pos - 3'h1;
          end else begin
            phase_cnt <= CNT_ZERO;
            bit_pos <= MSB_POS;
            sar <= RESULT_RESET;
            slot <= slot + 2'h1;
            if (slot == LAST_SLOT && !cont_mode) begin
              state <= IDLE;
            end else begin
              state <= SAMPLE;
            end
          end
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // results land only from the converter, never from the bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < RESULT_COUNT; i++) begin
        result[i] <= RESULT_RESET;
      end
    end else if (store && !ctrl_wr) begin
      result[slot] <= resolved;
    end
  end

  // outputs toward the analog mux and converter core
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog <= '0;
    end else begin
      analog.chan_select <= next_chan;
      analog.sample_enable <= (state == SAMPLE) && !low_power;
      analog.dac_code <= sar;
      analog.busy <= running;
    end
  end

  // read data stands one cycle after the strobe
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = READ_ZERO;
    if (req.rd) begin
      case (req.addr)
        CTRL_ADDR: next_rdata = ctrl_view;
        RESULT_ONE_ADDR: next_rdata = result[0];
        RESULT_TWO_ADDR: next_rdata = result[1];
        RESULT_THREE_ADDR: next_rdata = result[2];
        RESULT_FOUR_ADDR: next_rdata = result[3];
        default: next_rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= READ_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule

// file: hdl/adc_seq_pkg.sv
// constants, types and register map of the converter sequence control
// What this block does
// - group mode, single pass: convert four group channels once into results one to four
// - group mode, continuous: keep converting the group, results overwritten cyclically
// - low-power entry suspends current channel; on exit resample it and continue
// - after wait mode the first conversion is already valid
// - control bits read and write, done flag read-only, bit 6 reads zero
// - any control write abandons a running sequence and starts a fresh one
// - done flag sets when four results valid, clears on control write
// - continuous mode sets the done flag after the first four conversions
// - single mode converts the selected channel four times in a row
// - group mode ignores low select bits; upper two pick the group
// - select code picks input, reference or test; in group mode channel low bits give result slot
// - four read-only 8-bit result registers ignore writes
// - the sequence begins one clock after the control write
// - single mode continuous keeps converting, results overwritten cyclically
package adc_seq_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RESULT_COUNT = 4;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'h1030;
  localparam logic [ADDR_W-1:0] RESULT_ONE_ADDR = 16'h1031;
  localparam logic [ADDR_W-1:0] RESULT_TWO_ADDR = 16'h1032;
  localparam logic [ADDR_W-1:0] RESULT_THREE_ADDR = 16'h1033;
  localparam logic [ADDR_W-1:0] RESULT_FOUR_ADDR = 16'h1034;
  localparam int DONE_BIT = 7;
  localparam int CONT_BIT = 5;
  localparam int GROUP_BIT = 4;
  localparam logic DONE_RESET = 1'h1;
  localparam logic CONT_RESET = 1'h0;
  localparam logic GROUP_RESET = 1'h0;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RESULT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [2:0] MSB_POS = 3'h7;
  localparam logic [2:0] LSB_POS = 3'h0;
  localparam logic [1:0] LAST_SLOT = 2'h3;
  localparam logic [1:0] FIRST_SLOT = 2'h0;
  localparam logic [7:0] ONE_HOT_LSB = 8'h01;
  localparam int SAMPLE_TICKS = 12;
  localparam int BIT_TICKS = 2;
  localparam int TICK_DIV = 4;
  localparam int STOP_SETTLE_MS = 10;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SAMPLE = 2'b01,
    CONVERT = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] chan_select;
    logic sample_enable;
    logic [DATA_W-1:0] dac_code;
    logic busy;
  } analog_ctrl_t;
endpackage

// file: tb/adc_seq_sva.sv
// port assertions of the converter sequence control
`timescale 1ns/1ps
module adc_seq_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire adc_seq_pkg::reg_req_t req,
  input wire logic [adc_seq_pkg::DATA_W-1:0] rdata,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic comp_in,
  input wire adc_seq_pkg::analog_ctrl_t analog
);
  import adc_seq_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] ctrl_q;
  wire ctrl_wr = req.wr && req.addr == CTRL_ADDR;
  wire ctrl_rd = req.rd && req.addr == CTRL_ADDR;
  wire low = stop_mode || wait_mode;
  // shadow of the last control write, to judge the channel the mux sees
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00;
    end else if (ctrl_wr) begin
      ctrl_q <= req.wdata;
    end
  end
  bit6_zero_a: assert property (ctrl_rd |=> rdata[6] == 1'b0)
    else $error("bit 6 read nonzero");
  // state moves one clock after the write, the registered outputs show it one clock later
  start_next_a: assert property (ctrl_wr && !low ##1 !low |=> analog.busy && analog.sample_enable)
    else $error("sequence not started after control write");
  done_clear_a: assert property (ctrl_wr ##[1:2] ctrl_rd |=> !rdata[DONE_BIT])
    else $error("done flag not cleared by write");
  suspend_a: assert property (low && analog.busy && !req.wr |=> !analog.sample_enable)
    else $error("sampling during low power");
  resume_a: assert property ($fell(stop_mode) && !wait_mode && analog.busy |-> ##[1:8] analog.sample_enable)
    else $error("channel not resampled after stop");
  idle_quiet_a: assert property (!analog.busy |-> !analog.sample_enable)
    else $error("sampling while halted");
  // the mux code lags the shadow by one clock just after a write
  single_chan_a: assert property (analog.sample_enable && !$past(ctrl_wr) && !ctrl_q[GROUP_BIT]
    |-> analog.chan_select == ctrl_q[3:0])
    else $error("single mode channel wrong");
  group_chan_a: assert property (analog.sample_enable && !$past(ctrl_wr) && ctrl_q[GROUP_BIT]
    |-> analog.chan_select[3:2] == ctrl_q[3:2])
    else $error("group mode channel outside group");
  result_wr_a: assert property (req.wr && req.addr != CTRL_ADDR && !analog.busy |=> !analog.busy)
    else $error("result write started a sequence");
endmodule

// file: tb/analog_core_model.sv
// analog core model: each channel holds a fixed level
`timescale 1ns/1ps
module analog_core_model (
  input wire logic clk_sys,
  input wire adc_seq_pkg::analog_ctrl_t analog,
  output logic comp_in
);
  import adc_seq_pkg::*;
  logic [7:0] held;
  // level is tracked only while sampling, as a real hold capacitor would
  always_ff @(posedge clk_sys) begin
    if (analog.sample_enable) begin
      held <= {analog.chan_select, ~analog.chan_select};
    end
  end
  assign comp_in = held >= analog.dac_code;
endmodule

// file: tb/tb.sv
// self-checking bench of the converter sequence control
`timescale 1ns/1ps
module tb;
  import adc_seq_pkg::*;
  logic clk_sys;
  logic rst_n;
  reg_req_t req;
  logic [DATA_W-1:0] rdata;
  logic stop_mode;
  logic wait_mode;
  logic comp_in;
  analog_ctrl_t analog;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] got;
  adc_sequence_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .comp_in(comp_in), .analog(analog));
  analog_core_model u_core (.clk_sys(clk_sys), .analog(analog), .comp_in(comp_in));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    checks_done++;
    if (act !== exp) begin
      mismatches++;
      $display("unexpected at %0t exp %h got %h", $time, exp, act);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask
  // bounded wait for the sequence to halt
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    while (analog.busy !== 1'b0) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 5000) begin
        mismatches++;
        close_out();
      end
    end
  endtask
  task automatic results(input logic [3:0] first, input bit step);
    logic [3:0] ch;
    for (int i = 0; i < 4; i++) begin
      ch = step ? first + 4'(i) : first;
      rd(RESULT_ONE_ADDR + 16'(i));
      chk({ch, ~ch}, got);
    end
  endtask
  task automatic t_basic();
    rd(CTRL_ADDR);
    chk(8'h80, got);
    rd(16'h1040);
    chk(8'h00, got);
    wr(CTRL_ADDR, 8'h43);
    rd(CTRL_ADDR);
    chk(8'h03, got);
    wait_idle();
    results(4'h3, 1'b0);
    rd(CTRL_ADDR);
    chk(8'h83, got);
    wr(CTRL_ADDR, 8'h17);
    wait_idle();
    results(4'h4, 1'b1);
    wr(RESULT_ONE_ADDR, 8'haa);
    rd(RESULT_ONE_ADDR);
    chk(8'h4b, got);
    $display("single, group and read-only test done");
  endtask
  task automatic t_cont();
    int n;
    wr(CTRL_ADDR, 8'h3d);
    n = 0;
    got = 8'h00;
    while (got[7] !== 1'b1 && n < 1000) begin
      rd(CTRL_ADDR);
      n++;
    end
    if (n >= 1000) begin
      mismatches++;
      close_out();
    end
    chk(8'hbd, got);
    results(4'hc, 1'b1);
    repeat (600) @(posedge clk_sys);
    rd(CTRL_ADDR);
    chk(8'hbd, got);
    chk(8'h01, {7'h00, analog.busy});
    wr(CTRL_ADDR, 8'h05);
    rd(CTRL_ADDR);
    chk(8'h05, got);
    wait_idle();
    results(4'h5, 1'b0);
    $display("continuous and abort test done");
  endtask
  task automatic t_low();
    wr(CTRL_ADDR, 8'h01);
    repeat (100) @(posedge clk_sys);
    stop_mode <= 1'b1;
    repeat (200) @(posedge clk_sys);
    // the model settles at once, so the software settling wait is cut short
    stop_mode <= 1'b0;
    repeat (150) @(posedge clk_sys);
    wait_mode <= 1'b1;
    repeat (60) @(posedge clk_sys);
    wait_mode <= 1'b0;
    wait_idle();
    results(4'h1, 1'b0);
    $display("low power test done");
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    stop_mode = 1'b0;
    wait_mode = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_basic();
    t_cont();
    t_low();
    close_out();
  end
endmodule
bind adc_sequence_control adc_seq_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
  .rdata(rdata), .stop_mode(stop_mode), .wait_mode(wait_mode), .comp_in(comp_in),
  .analog(analog));
